//--- logic/rx_buf_consts.vh
// Register offsets, field positions and reset values for the receive buffer block
`ifndef RX_BUF_CONSTS_VH
`define RX_BUF_CONSTS_VH
`define OFS_STATUS      8'h00
`define OFS_CONTROL     8'h04
`define OFS_FRAME_CFG   8'h08
`define OFS_DATA        8'h0c
`define OFS_FRAME_IN    8'h10
// Status register fields
`define ST_RX_COMPLETE  7
`define ST_FRAME_ERR    4
`define ST_OVERRUN      3
`define ST_PARITY_ERR   2
// Control register fields
`define CT_RX_IRQ_EN    7
`define CT_RX_ENABLE    4
`define CT_RX_NINTH     1
`define CT_TX_NINTH     0
// Frame config fields
`define FC_PARITY_EN    5
`define FC_PARITY_ODD   4
`define FC_STOP_COUNT   3
`define FC_CSZ_HI       2
`define FC_CSZ_LO       0
`define CONTROL_RESET   8'h00
`define FRAME_CFG_RESET 8'h06
`define CSZ_NINE        3'h7
`define FIFO_DEPTH      2
`endif

//--- logic/rx_fifo2.v
// Two-entry receive buffer holding data, ninth bit and error status per frame
`timescale 1ns/100ps
module rx_fifo2 (
    input  wire        hclk,      // System clock
    input  wire        hresetn,   // Async reset, active low
    input  wire        flush,     // Empty the buffer at once
    input  wire        push,      // Store one frame
    input  wire [11:0] push_data, // {fe,dor,upe,bit8,data}
    input  wire        pop,       // Advance the read side
    output wire [11:0] head,      // Oldest unread entry
    output wire        not_empty, // Holds unread data
    output wire        full       // Holds two frames
);
    reg  [11:0] mem [0:1];
    reg         wr_ptr_reg;
    reg         rd_ptr_reg;
    reg  [1:0]  count_reg;
    wire        do_pop;
    wire        do_push;

    assign do_pop    = pop && (count_reg != 2'h0);
    assign do_push   = push && (count_reg != 2'h2 || do_pop);
    assign head      = mem[rd_ptr_reg];
    assign not_empty = (count_reg != 2'h0);
    assign full      = (count_reg == 2'h2);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
            mem[0]     <= 12'h000;
            mem[1]     <= 12'h000;
        end else if (flush) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end else begin
            if (do_push) begin
                mem[wr_ptr_reg] <= push_data;
                wr_ptr_reg      <= ~wr_ptr_reg;
            end
            if (do_pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, do_push} - {1'b0, do_pop};
        end
    end
endmodule // rx_fifo2

//--- logic/usart_receive_buffer_status.v
// Receive buffer, status flags and parity check of a serial receiver with an AHB-Lite slave
// What this block does
// - Nine-bit mode stores ninth bit per frame; software reads it before low byte.
// - Reading the data location advances the buffer and its presented status.
// - Receive complete flag reads one exactly while unread data is buffered.
// - Clearing receiver enable flushes the buffer, clearing receive complete.
// - Interrupt requested as a level while flag, interrupt enable and global interrupt enable are set.
// - Frame, overrun and parity errors are buffered with their frame, readable in status.
// - Software writes to error flag positions have no effect.
// - Error flags never request an interrupt.
// - Frame error is one when the first stop bit was sampled zero.
// - Only the first stop bit is checked, whatever stop bit count.
// - Overrun raised when buffer full, shift register full and a new start bit comes.
// - Overrun clears once a frame moves into the buffer.
// - Parity check only with parity enable; odd select picks the sense.
// - Parity error stored with frame, zero when checking is off.
// - Disabling is immediate: reception dropped, buffer flushed, pin released.
// - Frame moves to buffer on first stop bit; second stop bit ignored.
// - Unused upper data bits of narrow frames read zero.
`timescale 1ns/100ps
`include "rx_buf_consts.vh"
module usart_receive_buffer_status (
    input  wire        hclk,          // System clock, 40 MHz
    input  wire        hresetn,       // Async reset, active low
    input  wire        hsel,          // AHB slave select
    input  wire [31:0] haddr,         // AHB address
    input  wire [1:0]  htrans,        // AHB transfer type
    input  wire        hwrite,        // AHB write
    input  wire [2:0]  hsize,         // AHB size
    input  wire [31:0] hwdata,        // AHB write data
    input  wire        hready,        // AHB bus ready
    output reg  [31:0] hrdata,        // AHB read data
    output reg         hreadyout,     // AHB slave ready
    output reg         hresp,         // AHB response, always OKAY
    input  wire        start_det,     // Recovery saw a valid start bit
    input  wire        frame_valid,   // First stop bit sampled, frame complete
    input  wire [8:0]  frame_data,    // Recovered data bits, LSB first received
    input  wire        frame_parity,  // Recovered parity bit
    input  wire        frame_stop,    // Recovered first stop bit
    input  wire        global_irq_en, // Global interrupt enable
    output reg         rx_irq,        // Receive complete interrupt request
    output reg         rx_pin_owned,  // Receiver overrides the pin function
    output reg         rx_abort       // Pulse: drop reception in progress
);
    reg  [7:0]  serial_control_reg;
    reg  [7:0]  serial_frame_config_reg;
    reg  [11:0] shift_reg;
    reg         shift_full_reg;
    reg         overrun_pend_reg;
    reg         ph_valid_reg;
    reg         ph_write_reg;
    reg  [7:0]  ph_addr_reg;
    reg         rx_enable_prev_reg;
    wire        rx_enable;
    wire        parity_enable_bit;
    wire        parity_odd_select;
    wire [2:0]  char_size_code;
    wire        flush;
    wire        addr_ok;
    wire        data_read;
    wire        push;
    wire [11:0] head;
    wire        rx_complete_flag;
    wire        buf_full;
    wire [8:0]  masked;
    wire        parity_err;
    wire [11:0] frame_word;
    wire [7:0]  status_val;
    wire [7:0]  control_val;
    wire [7:0]  head_data;
    wire        head_ninth;
    wire        head_parity_err;
    wire        head_overrun;
    wire        head_frame_err;
    wire        frame_err_in;
    wire [11:0] push_word;
    wire        addr_phase;
    wire        read_phase;
    wire        ctrl_write;
    wire        cfg_write;
    wire [31:0] read_word;

    // Keep only the data bits the frame width uses
    function [8:0] mask_data;
        input [2:0] csz;
        input [8:0] d;
        begin
            case (csz)
                3'h0:    mask_data = {4'h0, d[4:0]};
                3'h1:    mask_data = {3'h0, d[5:0]};
                3'h2:    mask_data = {2'h0, d[6:0]};
                3'h3:    mask_data = {1'b0, d[7:0]};
                // Reserved codes fall back to eight bits
                3'h7:    mask_data = d;
                default: mask_data = {1'b0, d[7:0]};
            endcase
        end
    endfunction

    // Bus qualification shared by the phase tracker and the read path
    function bus_request;
        input       sel;
        input [1:0] trans;
        input       rdy;
        input       ok;
        begin
            bus_request = sel && trans[1] && rdy && ok;
        end
    endfunction

    // One when data and parity bit disagree with the selected sense
    function parity_mismatch;
        input [8:0] d;
        input       p;
        input       odd;
        begin
            parity_mismatch = (^d) ^ p ^ odd;
        end
    endfunction

    // Read mux; unmapped offsets return zero
    function [31:0] read_value;
        input [7:0] a;
        input [7:0] st;
        input [7:0] ct;
        input [7:0] fc;
        input [7:0] dt;
        begin
            case (a)
                `OFS_STATUS:    read_value = {24'h000000, st};
                `OFS_CONTROL:   read_value = {24'h000000, ct};
                `OFS_FRAME_CFG: read_value = {24'h000000, fc};
                `OFS_DATA:      read_value = {24'h000000, dt};
                default:        read_value = 32'h00000000;
            endcase
        end
    endfunction

    assign rx_enable         = serial_control_reg[`CT_RX_ENABLE];
    assign parity_enable_bit = serial_frame_config_reg[`FC_PARITY_EN];
    assign parity_odd_select = serial_frame_config_reg[`FC_PARITY_ODD];
    assign char_size_code    = serial_frame_config_reg[`FC_CSZ_HI:`FC_CSZ_LO];
    assign flush             = !rx_enable;
    assign masked            = mask_data(char_size_code, frame_data);
    // Even parity: xor of data and parity bit is zero; odd select inverts the sense
    assign parity_err        = parity_enable_bit &&
                               parity_mismatch(masked, frame_parity, parity_odd_select);
    // Only the first stop bit is looked at; the stop bit count setting is ignored
    assign frame_err_in      = !frame_stop;
    assign frame_word        = {frame_err_in, 1'b0, parity_err, masked};

    // Only aligned whole-word accesses decode
    assign addr_ok    = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);
    assign addr_phase = bus_request(hsel, htrans, hready, addr_ok);
    assign read_phase = addr_phase && !hwrite;
    // Status is not decoded for writes: its flag positions live in the buffer
    assign ctrl_write = ph_valid_reg && ph_write_reg && (ph_addr_reg == `OFS_CONTROL);
    assign cfg_write  = ph_valid_reg && ph_write_reg && (ph_addr_reg == `OFS_FRAME_CFG);
    assign read_word  = read_value(haddr[7:0], status_val, control_val, serial_frame_config_reg, head_data);
    assign data_read = ph_valid_reg && !ph_write_reg && (ph_addr_reg == `OFS_DATA);
    // Shift register drains into the buffer whenever a slot is free this cycle
    assign push      = shift_full_reg && (!buf_full || data_read);

    rx_fifo2 u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .flush     (flush),
        .push      (push),
        .push_data (push_word),
        .pop       (data_read),
        .head      (head),
        .not_empty (rx_complete_flag),
        .full      (buf_full)
    );

    // Overrun travels with the frame that enters after the loss
    assign push_word       = {shift_reg[11], overrun_pend_reg, shift_reg[9:0]};

    assign head_data       = head[7:0];
    assign head_ninth      = head[8];
    assign head_parity_err = head[9];
    assign head_overrun    = head[10];
    assign head_frame_err  = head[11];

    assign status_val  = {rx_complete_flag, 2'b00, head_frame_err, head_overrun, head_parity_err, 2'b00};
    assign control_val = {serial_control_reg[7:2], head_ninth, serial_control_reg[0]};

    // Overrun: a start bit while both slots and the shift stage are taken
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overrun_pend_reg <= 1'b0;
        end else if (flush) begin
            overrun_pend_reg <= 1'b0;
        end else if (start_det && buf_full && shift_full_reg && !push) begin
            overrun_pend_reg <= 1'b1;
        end else if (push) begin
            overrun_pend_reg <= 1'b0;
        end
    end

    // Receive shift stage; a new frame replaces one still waiting, the overrun marks the loss
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_reg      <= 12'h000;
            shift_full_reg <= 1'b0;
        end else if (flush) begin
            shift_full_reg <= 1'b0;
        end else if (frame_valid) begin
            shift_reg      <= frame_word;
            shift_full_reg <= 1'b1;
        end else if (push) begin
            shift_full_reg <= 1'b0;
        end
    end

    // AHB-Lite slave: zero wait states, writes land at the end of the data phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_addr_reg  <= 8'h00;
        end else begin
            ph_valid_reg <= addr_phase;
            ph_write_reg <= hwrite;
            ph_addr_reg  <= haddr[7:0];
        end
    end

    // Ninth receive bit is read-only
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_control_reg <= `CONTROL_RESET;
        end else if (ctrl_write) begin
            serial_control_reg <= {hwdata[7:2], 1'b0, hwdata[0]};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_frame_config_reg <= `FRAME_CFG_RESET;
        end else if (cfg_write) begin
            serial_frame_config_reg <= hwdata[7:0];
        end
    end

    // Read data is captured in the address phase, so a data read shows the head before it pops
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (read_phase) begin
            hrdata <= read_word;
        end else begin
            hrdata <= 32'h00000000;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Level request; error flags never feed it
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= rx_complete_flag && serial_control_reg[`CT_RX_IRQ_EN] && global_irq_en;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_pin_owned <= 1'b0;
        end else begin
            rx_pin_owned <= rx_enable;
        end
    end

    // Abort pulses once when the enable falls
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_enable_prev_reg <= 1'b0;
            rx_abort           <= 1'b0;
        end else begin
            rx_enable_prev_reg <= rx_enable;
            rx_abort           <= rx_enable_prev_reg && !rx_enable;
        end
    end
endmodule // usart_receive_buffer_status

//--- test/usart_receive_buffer_status_monitor.sv
// Port checker of the receive buffer block
`timescale 1ns/100ps
`include "rx_buf_consts.vh"
module usart_receive_buffer_status_monitor (
    input wire        hclk, hresetn, hsel, hwrite, hready, // Clock, reset, bus control
    input wire [31:0] haddr, hrdata,                       // Address, read data
    input wire [1:0]  htrans,                              // Transfer type
    input wire        hreadyout, hresp, global_irq_en,     // Answer, global enable
    input wire        rx_irq, rx_pin_owned, rx_abort       // Receiver outputs
);
    reg       dp_reg = 1'b0;
    reg       rd_reg = 1'b0;
    reg [7:0] addr_reg = 8'h00;
    always @(posedge hclk) begin
        dp_reg   <= hsel & htrans[1] & hready;
        rd_reg   <= hsel & htrans[1] & hready & ~hwrite;
        addr_reg <= haddr[7:0];
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
    a_okay: assert property (p_okay) else $error("slave answer not zero wait OKAY");
    property p_idle_rdata; !rd_reg |-> hrdata == 32'h0; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read");
    property p_data_upper; rd_reg && addr_reg == `OFS_DATA |-> hrdata[31:8] == 24'h0; endproperty
    a_data_upper: assert property (p_data_upper) else $error("data upper bits set");
    property p_status_bits; rd_reg && addr_reg == `OFS_STATUS |-> (hrdata & 32'hffffff63) == 32'h0; endproperty
    a_status_bits: assert property (p_status_bits) else $error("status unused bits set");
    property p_abort_fall; $fell(rx_pin_owned) |-> rx_abort; endproperty
    a_abort_fall: assert property (p_abort_fall) else $error("no abort on disable");
    // Re-enable may follow at once, so only the pulse itself is bounded
    property p_abort_pulse; rx_abort |-> !rx_pin_owned ##1 !rx_abort; endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort not one cycle");
    property p_irq_gate; !global_irq_en |=> !rx_irq; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");
    property p_irq_level; rx_irq && global_irq_en && !dp_reg && !$past(dp_reg) |=> rx_irq; endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq dropped without access");
endmodule // usart_receive_buffer_status_monitor
bind usart_receive_buffer_status usart_receive_buffer_status_monitor i_monitor (.hclk, .hresetn, .hsel,
    .hwrite, .hready, .haddr, .hrdata, .htrans, .hreadyout, .hresp, .global_irq_en, .rx_irq, .rx_pin_owned,
    .rx_abort);

//--- test/rx_frame_source.sv
// Remote transmitter as seen after data recovery
`timescale 1ns/100ps
module rx_frame_source (
    input  wire       hclk,                 // Clock
    output reg        start_det = 1'b0,     // Start bit found
    output reg        frame_valid = 1'b0,   // First stop bit sampled
    output reg  [8:0] frame_data = 9'h155,  // Data bits
    output reg        frame_parity = 1'b0,  // Parity bit
    output reg        frame_stop = 1'b1     // First stop bit
);
    task automatic send(input [8:0] d, input p, input s);
        @(posedge hclk) start_det <= 1'b1;
        @(posedge hclk) start_det <= 1'b0;
        @(posedge hclk) {frame_valid, frame_data, frame_parity, frame_stop} <= {1'b1, d, p, s};
        // Lines flip after the frame so a late sample cannot match by luck
        @(posedge hclk) {frame_valid, frame_data, frame_parity, frame_stop} <= {1'b0, ~d, ~p, ~s};
        repeat (2) @(posedge hclk);
    endtask
endmodule // rx_frame_source

//--- test/usart_receive_buffer_status_tb.sv
// Bench for the receive buffer block
`timescale 1ns/100ps
`include "rx_buf_consts.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module usart_receive_buffer_status_tb;
    reg         hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, global_irq_en = 1'b0;
    reg  [1:0]  htrans = 2'b00;
    reg  [31:0] haddr = 32'h0, hwdata = 32'h0, v;
    wire [31:0] hrdata;
    wire [8:0]  frame_data;
    wire        hreadyout, hresp, rx_irq, rx_pin_owned, rx_abort, start_det, frame_valid, frame_parity, frame_stop;
    integer     err_total = 0, checks_done = 0, i;
    usart_receive_buffer_status i_usart_receive_buffer_status (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
        .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .start_det,
        .frame_valid, .frame_data, .frame_parity, .frame_stop, .global_irq_en, .rx_irq, .rx_pin_owned, .rx_abort);
    rx_frame_source i_rx_frame_source (.hclk, .start_det, .frame_valid, .frame_data, .frame_parity, .frame_stop);
    task automatic xfer(input [7:0] a, input w, input [31:0] d, output [31:0] r);
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d); xfer(a, 1'b1, d, v); endtask
    task automatic rd_chk(input [7:0] a, input [31:0] e);
        xfer(a, 1'b0, 32'h0, v);
        `CHK(v, e)
    endtask
    // Status first, ninth bit next, and the popping data read last
    task automatic rd_frame(input [7:0] st, input [7:0] ctl, input [7:0] dat);
        rd_chk(`OFS_STATUS, {24'h0, st});
        rd_chk(`OFS_CONTROL, {24'h0, ctl});
        rd_chk(`OFS_DATA, {24'h0, dat});
    endtask
    task done(input integer n); $display("test %0d finished", n); endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial forever #12.5 hclk = ~hclk;
    initial begin
        #600000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(`OFS_CONTROL, 32'h00);
        rd_chk(`OFS_FRAME_CFG, 32'h06);
        wr(`OFS_CONTROL, 32'h10);
        rd_frame(8'h00, 8'h10, 8'h00);
        rd_chk(8'h10, 32'h00);
        done(1);
        wr(`OFS_FRAME_CFG, 32'h27);
        i_rx_frame_source.send(9'h1a5, 1'b1, 1'b1);
        i_rx_frame_source.send(9'h0f0, 1'b1, 1'b0);
        rd_frame(8'h80, 8'h12, 8'ha5);
        wr(`OFS_STATUS, 32'h00);
        rd_frame(8'h94, 8'h10, 8'hf0);
        done(2);
        // Only even checking with a wrong parity bit may flag an error
        for (i = 0; i < 4; i = i + 1) begin
            wr(`OFS_FRAME_CFG, 32'h0b | (i << 4));
            i_rx_frame_source.send(9'h003, 1'b1, 1'b1);
            rd_frame((i == 2) ? 8'h84 : 8'h80, 8'h10, 8'h03);
        end
        wr(`OFS_FRAME_CFG, 32'h00);
        i_rx_frame_source.send(9'h1ff, 1'b0, 1'b1);
        rd_frame(8'h80, 8'h10, 8'h1f);
        done(3);
        wr(`OFS_FRAME_CFG, 32'h06);
        for (i = 1; i < 5; i = i + 1) i_rx_frame_source.send(i[8:0] * 9'h011, 1'b0, 1'b1);
        rd_frame(8'h80, 8'h10, 8'h11);
        rd_frame(8'h80, 8'h10, 8'h22);
        rd_frame(8'h88, 8'h10, 8'h44);
        i_rx_frame_source.send(9'h055, 1'b0, 1'b1);
        rd_frame(8'h80, 8'h10, 8'h55);
        i_rx_frame_source.send(9'h012, 1'b0, 1'b1);
        i_rx_frame_source.send(9'h034, 1'b0, 1'b1);
        rd_chk(`OFS_DATA, 32'h12);
        rd_chk(`OFS_DATA, 32'h34);
        rd_chk(`OFS_STATUS, 32'h00);
        done(4);
        global_irq_en <= 1'b1;
        wr(`OFS_CONTROL, 32'h90);
        i_rx_frame_source.send(9'h066, 1'b0, 1'b0);
        repeat (3) @(posedge hclk);
        `CHK(rx_irq, 1'b1)
        rd_frame(8'h90, 8'h90, 8'h66);
        repeat (2) @(posedge hclk);
        `CHK(rx_irq, 1'b0)
        done(5);
        i_rx_frame_source.send(9'h077, 1'b0, 1'b1);
        wr(`OFS_CONTROL, 32'h00);
        wr(`OFS_CONTROL, 32'h10);
        rd_chk(`OFS_STATUS, 32'h00);
        `CHK(rx_pin_owned, 1'b1)
        done(6);
        final_report;
    end
endmodule // usart_receive_buffer_status_tb
